// ===== rtl/adc_mux_select.sv
// The AHB-Lite slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
module adc_mux_select (
   input wire logic MCLK_I,
   input wire logic RST_N_I,
   // AHB-Lite slave
   input wire logic HSEL_I,
   input wire logic [31:0] HADDR_I,
   input wire logic [1:0] HTRANS_I,
   input wire logic HWRITE_I,
   input wire logic [2:0] HSIZE_I,
   input wire logic [31:0] HWDATA_I,
   input wire logic HREADY_I,
   output logic [31:0] HRDATA_O,
   output logic HREADYOUT_O,
   output logic HRESP_O,
   // Sequencer, same clock
   input wire logic SCAN_ACTIVE_I,
   input wire logic [7:0] SCAN_SEL_I,
   // Analog switch and bias controls
   output logic [15:0] VINP_SW_O,
   output logic [15:0] VINN_SW_O,
   output logic [1:0] BURNOUT_SRC_O,
   output logic [1:0] BURNOUT_SINK_O
);
   // ==========================================================
   // Declarations
   // ==========================================================
   logic [1:0] cs_sel_reg, cs_sel_next; // Burnout level field
   logic [7:0] input_select_field_reg, input_select_field_next;
   logic wr_pend_reg, wr_pend_next; // Write data phase pending
   logic [31:0] wr_addr_reg, wr_addr_next; // Latched write address
   logic [31:0] rdata_reg, rdata_next; // Read data for data phase
   logic [7:0] applied_reg, applied_next; // Select in force
   logic [15:0] sw_p_reg, sw_p_next;
   logic [15:0] sw_n_reg, sw_n_next;
   logic [1:0] burn_reg, burn_next; // Gated burnout level
   logic temp_reg, temp_next; // Temperature sensor in use
   logic auto_reg, auto_next; // Sequencer owns selectors
   logic [7:0] eff_sel; // Select value from active owner
   logic temp_sel; // Effective value picks the sensor
   logic addr_ok; // Valid address phase seen
   logic cfg_wr; // Burnout field written this cycle
   logic sel_wr; // Select field written this cycle
   logic [31:0] status_word;

   sel_decode_if pos_if ();
   sel_decode_if neg_if ();

   // ==========================================================
   // Selector decoders
   // ==========================================================
   // Two separate instances, so no code of one limits the other
   assign pos_if.code = eff_sel[adc_mux_pkg::POS_MSB:adc_mux_pkg::POS_LSB];
   assign neg_if.code = eff_sel[adc_mux_pkg::NEG_MSB:adc_mux_pkg::NEG_LSB];

   mux_code_decoder u_pos_dec (
      .port (pos_if.dec)
   );
   mux_code_decoder u_neg_dec (
      .port (neg_if.dec)
   );

   // ==========================================================
   // Select ownership and burnout gating
   // ==========================================================
   // Sequencer output wins while it runs; field is untouched
   always_comb begin
      eff_sel = SCAN_ACTIVE_I ? SCAN_SEL_I : input_select_field_reg;
      temp_sel = (eff_sel == adc_mux_pkg::TEMP_SENSOR_SEL);
   end

   // Next values of the analog controls
   always_comb begin
      applied_next = eff_sel;
      sw_p_next = pos_if.sw;
      sw_n_next = neg_if.sw;
      auto_next = SCAN_ACTIVE_I;
      temp_next = temp_sel;
      // No conversion or shutdown term here on purpose
      if (temp_sel) begin
         burn_next = adc_mux_pkg::CS_SEL_OFF;
      end else begin
         burn_next = cs_sel_reg;
      end
   end

   // Analog controls come straight from flops, glitch free
   always_ff @(posedge MCLK_I) begin
      if (!RST_N_I) begin
         applied_reg <= adc_mux_pkg::INPUT_SELECT_RST;
         sw_p_reg <= 16'h0000;
         sw_n_reg <= 16'h0000;
         burn_reg <= adc_mux_pkg::CS_SEL_OFF;
         temp_reg <= 1'b0;
         auto_reg <= 1'b0;
      end else begin
         applied_reg <= applied_next;
         sw_p_reg <= sw_p_next;
         sw_n_reg <= sw_n_next;
         burn_reg <= burn_next;
         temp_reg <= temp_next;
         auto_reg <= auto_next;
      end
   end

   assign VINP_SW_O = sw_p_reg;
   assign VINN_SW_O = sw_n_reg;
   // Same level on source and sink, so the loop current balances
   assign BURNOUT_SRC_O = burn_reg;
   assign BURNOUT_SINK_O = burn_reg;

   // ==========================================================
   // AHB-Lite slave
   // ==========================================================
   // Zero wait states; only whole-word writes change anything
   always_comb begin
      addr_ok = HSEL_I && HTRANS_I[1] && HREADY_I;
      cfg_wr = wr_pend_reg &&
               (wr_addr_reg == adc_mux_pkg::OFS_CONFIG_REG_ZERO);
      sel_wr = wr_pend_reg &&
               (wr_addr_reg == adc_mux_pkg::OFS_INPUT_SELECT);
      status_word = adc_mux_pkg::RDATA_ZERO;
      status_word[adc_mux_pkg::ST_SEL_MSB:adc_mux_pkg::ST_SEL_LSB] =
         applied_reg;
      status_word[adc_mux_pkg::ST_AUTO_BIT] = auto_reg;
      status_word[adc_mux_pkg::ST_TEMP_BIT] = temp_reg;
      status_word[adc_mux_pkg::ST_BURN_BIT] =
         (burn_reg != adc_mux_pkg::CS_SEL_OFF);
      wr_pend_next = addr_ok && HWRITE_I &&
                     (HSIZE_I == adc_mux_pkg::HSIZE_WORD);
      wr_addr_next = addr_ok ? HADDR_I : wr_addr_reg;
      rdata_next = rdata_reg;
      if (addr_ok && !HWRITE_I) begin
         rdata_next = adc_mux_pkg::RDATA_ZERO; // Unmapped reads zero
         unique case (HADDR_I)
            adc_mux_pkg::OFS_CONFIG_REG_ZERO: begin
               rdata_next[adc_mux_pkg::CS_SEL_MSB:adc_mux_pkg::CS_SEL_LSB]
                  = cs_sel_reg;
            end
            adc_mux_pkg::OFS_INPUT_SELECT: begin
               rdata_next[adc_mux_pkg::POS_MSB:adc_mux_pkg::NEG_LSB] =
                  input_select_field_reg;
            end
            adc_mux_pkg::OFS_STATUS: begin
               rdata_next = status_word;
            end
            default: begin
               rdata_next = adc_mux_pkg::RDATA_ZERO;
            end
         endcase
      end
      // Writable in every mode, no state check
      cs_sel_next = cfg_wr ?
         HWDATA_I[adc_mux_pkg::CS_SEL_MSB:adc_mux_pkg::CS_SEL_LSB] :
         cs_sel_reg;
      // Field still accepts writes in auto mode, applied later
      input_select_field_next = sel_wr ?
         HWDATA_I[adc_mux_pkg::POS_MSB:adc_mux_pkg::NEG_LSB] :
         input_select_field_reg;
   end

   // Bus state and software fields
   always_ff @(posedge MCLK_I) begin
      if (!RST_N_I) begin
         cs_sel_reg <= adc_mux_pkg::CS_SEL_RST;
         input_select_field_reg <= adc_mux_pkg::INPUT_SELECT_RST;
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= adc_mux_pkg::RDATA_ZERO;
         rdata_reg <= adc_mux_pkg::RDATA_ZERO;
      end else begin
         cs_sel_reg <= cs_sel_next;
         input_select_field_reg <= input_select_field_next;
         wr_pend_reg <= wr_pend_next;
         wr_addr_reg <= wr_addr_next;
         rdata_reg <= rdata_next;
      end
   end

   assign HRDATA_O = rdata_reg;
   assign HREADYOUT_O = 1'b1;
   assign HRESP_O = 1'b0; // Always OKAY

   // ==========================================================
   // Assertions
   // ==========================================================
   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (!RST_N_I);

   property p_pos_follows;
      (eff_sel[7:4] != adc_mux_pkg::CODE_RESERVED) |=>
         (VINP_SW_O[$past(eff_sel[7:4])] && $onehot(VINP_SW_O));
   endproperty
   a_pos_follows: assert property (p_pos_follows)
      else $error("Positive switch does not match upper nibble");

   property p_neg_follows;
      (eff_sel[3:0] != adc_mux_pkg::CODE_RESERVED) |=>
         (VINN_SW_O[$past(eff_sel[3:0])] && $onehot(VINN_SW_O));
   endproperty
   a_neg_follows: assert property (p_neg_follows)
      else $error("Negative switch does not match lower nibble");

   property p_reserved_open;
      (eff_sel[7:4] == adc_mux_pkg::CODE_RESERVED) |=>
         (VINP_SW_O == 16'h0000);
   endproperty
   a_reserved_open: assert property (p_reserved_open)
      else $error("Reserved code closed a switch");

   // Negative side floats on the reserved code as well
   property p_reserved_open_neg;
      (eff_sel[adc_mux_pkg::NEG_MSB:adc_mux_pkg::NEG_LSB] ==
         adc_mux_pkg::CODE_RESERVED) |=> (VINN_SW_O == 16'h0000);
   endproperty
   a_reserved_open_neg: assert property (p_reserved_open_neg)
      else $error("Reserved code closed a negative switch");

   property p_same_code;
      (eff_sel[7:4] == eff_sel[3:0]) |=> (VINP_SW_O == VINN_SW_O);
   endproperty
   a_same_code: assert property (p_same_code)
      else $error("Selectors differ for one shared code");

   property p_auto_owner;
      SCAN_ACTIVE_I |=> (applied_reg == $past(SCAN_SEL_I)) && auto_reg;
   endproperty
   a_auto_owner: assert property (p_auto_owner)
      else $error("Sequencer select not applied");

   property p_balanced;
      BURNOUT_SRC_O == BURNOUT_SINK_O;
   endproperty
   a_balanced: assert property (p_balanced)
      else $error("Burnout source and sink differ");

   property p_burn_on;
      !temp_sel |=> (BURNOUT_SRC_O == $past(cs_sel_reg));
   endproperty
   a_burn_on: assert property (p_burn_on)
      else $error("Burnout level not driven");

   property p_cfg_write;
      cfg_wr |=> (cs_sel_reg == $past(HWDATA_I[1:0])) ##1
         (temp_reg || BURNOUT_SRC_O == $past(cs_sel_reg));
   endproperty
   a_cfg_write: assert property (p_cfg_write)
      else $error("Burnout level write not taken");

   property p_temp_gate;
      (temp_sel && !cfg_wr) |=> (BURNOUT_SRC_O == adc_mux_pkg::CS_SEL_OFF)
         && (cs_sel_reg == $past(cs_sel_reg));
   endproperty
   a_temp_gate: assert property (p_temp_gate)
      else $error("Burnout not gated by temperature select");

   property p_temp_flag;
      (eff_sel == adc_mux_pkg::TEMP_SENSOR_SEL) |=> temp_reg;
   endproperty
   a_temp_flag: assert property (p_temp_flag)
      else $error("Temperature selection not recognised");

   property p_manual_hold;
      (!SCAN_ACTIVE_I && !sel_wr) |=>
         (applied_reg == $past(input_select_field_reg)) &&
         (input_select_field_reg == $past(input_select_field_reg));
   endproperty
   a_manual_hold: assert property (p_manual_hold)
      else $error("Manual select changed without a write");
endmodule : adc_mux_select

// ===== rtl/adc_mux_pkg.sv
// ==========================================================
// Constants for the input selector block
// ==========================================================
package adc_mux_pkg;
   // Register byte offsets on the bus
   localparam logic [31:0] OFS_CONFIG_REG_ZERO = 32'h0000_0000;
   localparam logic [31:0] OFS_INPUT_SELECT = 32'h0000_0004;
   localparam logic [31:0] OFS_STATUS = 32'h0000_0008;
   // Reset values
   localparam logic [1:0] CS_SEL_RST = 2'h0;
   localparam logic [7:0] INPUT_SELECT_RST = 8'h01;
   // Field positions of config_reg_zero
   localparam int CS_SEL_LSB = 0;
   localparam int CS_SEL_MSB = 1;
   // Field positions of the status word
   localparam int ST_SEL_LSB = 0;
   localparam int ST_SEL_MSB = 7;
   localparam int ST_AUTO_BIT = 8;
   localparam int ST_TEMP_BIT = 9;
   localparam int ST_BURN_BIT = 10;
   // Nibble layout of the select value
   localparam int POS_MSB = 7;
   localparam int POS_LSB = 4;
   localparam int NEG_MSB = 3;
   localparam int NEG_LSB = 0;
   // Source codes of one selector
   localparam logic [3:0] CODE_CH0 = 4'h0;
   localparam logic [3:0] CODE_CH7 = 4'h7;
   localparam logic [3:0] CODE_AGND = 4'h8;
   localparam logic [3:0] CODE_AVDD = 4'h9;
   localparam logic [3:0] CODE_RESERVED = 4'ha;
   localparam logic [3:0] CODE_REF_P = 4'hb;
   localparam logic [3:0] CODE_REF_M = 4'hc;
   localparam logic [3:0] CODE_TEMP_P = 4'hd;
   localparam logic [3:0] CODE_TEMP_M = 4'he;
   localparam logic [3:0] CODE_INTERNAL_COMMON_MODE = 4'hf;
   // Whole select value that picks the temperature sensor
   localparam logic [7:0] TEMP_SENSOR_SEL = 8'hde;
   // Burnout level meaning no current
   localparam logic [1:0] CS_SEL_OFF = 2'h0;
   // Bus encodings
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
endpackage : adc_mux_pkg

// ===== rtl/sel_decode_if.sv
`timescale 1ns/100ps
// ==========================================================
// Code to switch-enable link between selector and decoder
// ==========================================================
interface sel_decode_if;
   logic [3:0] code; // Four-bit source code
   logic [15:0] sw; // One-hot switch enables, all zero on the reserved code
   modport src (output code, input sw);
   modport dec (input code, output sw);
endinterface : sel_decode_if

// ===== rtl/mux_code_decoder.sv
`timescale 1ns/100ps
// ==========================================================
// One single-ended selector: code to one-hot switch, no switch on the reserved code
// ==========================================================
module mux_code_decoder (
   sel_decode_if.dec port
);
   // Reserved code closes no switch, leaving the input floating
   always_comb begin
      port.sw = 16'h0000;
      if (port.code != adc_mux_pkg::CODE_RESERVED) begin
         port.sw[port.code] = 1'b1;
      end
   end
endmodule : mux_code_decoder

// ===== dv/adc_host_model.sv
`timescale 1ns/100ps
// ==========================================================
// Host side: single-word AHB-Lite master
// ==========================================================
module adc_host_model (
   input wire logic clk_i,
   input wire logic hready_i,
   input wire logic [31:0] hrdata_i,
   output logic hsel_o,
   output logic [31:0] haddr_o,
   output logic [1:0] htrans_o,
   output logic hwrite_o,
   output logic [2:0] hsize_o,
   output logic [31:0] hwdata_o
);
   // Idle bus from time zero
   initial begin
      hsel_o = 1'b0;
      haddr_o = 32'h0000_0000;
      htrans_o = 2'h0;
      hwrite_o = 1'b0;
      hsize_o = 3'h2;
      hwdata_o = 32'h0000_0000;
   end
   // One transfer; each phase holds until hready is sampled high
   // Callers keep select codes off reserved values unless told to
   task automatic xfer(input logic w, input logic [31:0] a,
      input logic [2:0] s, input logic [31:0] d,
      output logic [31:0] q);
      @(posedge clk_i);
      hsel_o <= 1'b1;
      haddr_o <= a;
      htrans_o <= 2'h2;
      hwrite_o <= w;
      hsize_o <= s;
      // Stale write data is not left looking valid
      hwdata_o <= ~hwdata_o;
      do @(posedge clk_i); while (hready_i !== 1'b1);
      hsel_o <= 1'b0;
      htrans_o <= 2'h0;
      hwdata_o <= d;
      do @(posedge clk_i); while (hready_i !== 1'b1);
      // Read data taken at the data-phase edge
      q = hrdata_i;
   endtask : xfer
endmodule : adc_host_model

// ===== dv/adc_input_mux_select_tb_top.sv
`timescale 1ns/100ps
// ==========================================================
// Bench for the input selector block
// ==========================================================
module adc_input_mux_select_tb_top;
   typedef struct packed {
      logic sa;
      logic [7:0] ss;
      logic [7:0] fld;
      logic [1:0] cs;
      logic [1:0] eb;
   } row_t;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic scan_active = 1'b0;
   logic [7:0] scan_sel = 8'h00;
   logic hsel;
   logic [31:0] haddr;
   logic [1:0] htrans;
   logic hwrite;
   logic [2:0] hsize;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic hready;
   logic hresp;
   logic [15:0] vinp;
   logic [15:0] vinn;
   logic [1:0] bsrc;
   logic [1:0] bsink;
   int err_count = 0;
   int checked = 0;
   int cycles = 0;
   logic [31:0] q;
   logic [7:0] eff;
   // Auto mode, sequencer code, field, level, expected level
   row_t rows [10] = '{
      '{1'b0, 8'h00, 8'h07, 2'h1, 2'h1},
      '{1'b0, 8'h00, 8'h9b, 2'h2, 2'h2},
      '{1'b0, 8'h00, 8'h8c, 2'h3, 2'h3},
      '{1'b0, 8'h00, 8'hfa, 2'h3, 2'h3},
      '{1'b0, 8'h00, 8'hde, 2'h3, 2'h0},
      '{1'b0, 8'h00, 8'hed, 2'h3, 2'h3},
      '{1'b1, 8'hde, 8'h34, 2'h2, 2'h0},
      '{1'b1, 8'h56, 8'hde, 2'h2, 2'h2},
      '{1'b0, 8'h00, 8'ha4, 2'h1, 2'h1},
      '{1'b0, 8'h00, 8'h12, 2'h0, 2'h0}};

   // Clock at 50 ns period
   initial begin
      forever #25 mclk = ~mclk;
   end
   // Host partner drives the register bus
   adc_host_model u_host (.clk_i(mclk), .hready_i(hready),
      .hrdata_i(hrdata), .hsel_o(hsel), .haddr_o(haddr),
      .htrans_o(htrans), .hwrite_o(hwrite), .hsize_o(hsize),
      .hwdata_o(hwdata));
   adc_mux_select u_dut (.MCLK_I(mclk), .RST_N_I(rst_n),
      .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
      .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata),
      .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready),
      .HRESP_O(hresp), .SCAN_ACTIVE_I(scan_active),
      .SCAN_SEL_I(scan_sel), .VINP_SW_O(vinp), .VINN_SW_O(vinn),
      .BURNOUT_SRC_O(bsrc), .BURNOUT_SINK_O(bsink));

   // Reserved code closes no switch
   function automatic logic [15:0] dec(input logic [3:0] c);
      dec = (c == adc_mux_pkg::CODE_RESERVED) ? 16'h0000 : 16'h0001 << c;
   endfunction : dec
   task automatic chk(input string n, input logic [31:0] e,
      input logic [31:0] g);
      checked++;
      if (g !== e) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      u_host.xfer(1'b1, a, adc_mux_pkg::HSIZE_WORD, d, q);
   endtask : wr
   // Let the registered outputs settle, then sample between edges
   task automatic settle();
      repeat (2) @(posedge mclk);
      @(negedge mclk);
   endtask : settle
   // Switch and burnout outputs against selection and level
   task automatic chk_out(input logic [7:0] s, input logic [1:0] b);
      chk("vinp", {16'h0, dec(s[7:4])}, {16'h0, vinp});
      chk("vinn", {16'h0, dec(s[3:0])}, {16'h0, vinn});
      chk("bsrc", {30'h0, b}, {30'h0, bsrc});
      chk("bsink", {30'h0, b}, {30'h0, bsink});
      chk("hresp", 32'h0, {31'h0, hresp});
      chk("hready", 32'h1, {31'h0, hready});
   endtask : chk_out
   task automatic end_sim();
      if (err_count == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : end_sim
   // Hang guard
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 3000) begin
         err_count++;
         end_sim();
      end
   end

   // ==========================================================
   // Main sequence
   // ==========================================================
   initial begin
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      // Table rows, every code group on one side or the other
      foreach (rows[i]) begin
         @(posedge mclk);
         scan_active <= rows[i].sa;
         scan_sel <= rows[i].ss;
         wr(adc_mux_pkg::OFS_CONFIG_REG_ZERO, {30'h0, rows[i].cs});
         wr(adc_mux_pkg::OFS_INPUT_SELECT, {24'h0, rows[i].fld});
         settle();
         eff = rows[i].sa ? rows[i].ss : rows[i].fld;
         chk_out(eff, rows[i].eb);
         u_host.xfer(1'b0, adc_mux_pkg::OFS_STATUS, 3'h2, 32'h0, q);
         chk("status", {21'h0, rows[i].eb != 2'h0,
            eff == adc_mux_pkg::TEMP_SENSOR_SEL, rows[i].sa, eff},
            q);
         u_host.xfer(1'b0, adc_mux_pkg::OFS_INPUT_SELECT, 3'h2, 32'h0, q);
         chk("field", {24'h0, rows[i].fld}, q);
         u_host.xfer(1'b0, adc_mux_pkg::OFS_CONFIG_REG_ZERO, 3'h2, 32'h0, q);
         chk("level", {30'h0, rows[i].cs}, q);
      end
      // Field written during auto mode shows only once it ends
      @(posedge mclk);
      scan_active <= 1'b1;
      scan_sel <= 8'h11;
      wr(adc_mux_pkg::OFS_CONFIG_REG_ZERO, 32'h0000_0001);
      wr(adc_mux_pkg::OFS_INPUT_SELECT, 32'h0000_0023);
      settle();
      chk_out(8'h11, 2'h1);
      @(posedge mclk);
      scan_active <= 1'b0;
      settle();
      chk_out(8'h23, 2'h1);
      // Halfword, read-only and unmapped writes change nothing
      u_host.xfer(1'b1, adc_mux_pkg::OFS_INPUT_SELECT, 3'h1, 32'h45, q);
      wr(adc_mux_pkg::OFS_STATUS, 32'h0000_07ff);
      wr(32'h0000_000c, 32'h0000_0045);
      u_host.xfer(1'b0, 32'h0000_000c, 3'h2, 32'h0, q);
      chk("unmapped", 32'h0000_0000, q);
      settle();
      chk_out(8'h23, 2'h1);
      // Second reset mid-run restores defaults
      @(posedge mclk);
      rst_n <= 1'b0;
      repeat (5) @(posedge mclk);
      // Outputs cleared while reset is held
      @(negedge mclk);
      chk("vinp_rst", 32'h0, {16'h0, vinp});
      chk("bsrc_rst", 32'h0, {30'h0, bsrc});
      @(posedge mclk);
      rst_n <= 1'b1;
      u_host.xfer(1'b0, adc_mux_pkg::OFS_CONFIG_REG_ZERO, 3'h2, 32'h0, q);
      chk("cs_rst", {30'h0, adc_mux_pkg::CS_SEL_RST}, q);
      u_host.xfer(1'b0, adc_mux_pkg::OFS_INPUT_SELECT, 3'h2, 32'h0, q);
      chk("sel_rst", {24'h0, adc_mux_pkg::INPUT_SELECT_RST}, q);
      settle();
      chk_out(adc_mux_pkg::INPUT_SELECT_RST, 2'h0);
      end_sim();
   end
endmodule : adc_input_mux_select_tb_top
